// ==== core/oc_guard_pkg.sv ====
// Package: constants and carrier types for the four-port overcurrent guard.
// Assumes a single 100 MHz clock domain and a plain register port.
package oc_guard_pkg;
  localparam int          NUM_PORTS      = 4;
  localparam int          TIMER_W        = 16;
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 8;
  localparam int          CLK_MHZ        = 100;
  // Timing figures in microseconds, turned into cycles below
  localparam int          STARTUP_US     = 60;
  localparam int          STARTUP_CYC    = STARTUP_US * CLK_MHZ;
  localparam int          OVLD_UNIT_US   = 1;
  localparam int          OVLD_UNIT_CYC  = OVLD_UNIT_US * CLK_MHZ;
  // Recovery counts up one step per this many down-steps
  localparam logic [3:0]  RECOVER_DIV    = 4'h8;
  // Register offsets
  localparam logic [3:0]  REG_CONTROL    = 4'h0;
  localparam logic [3:0]  REG_HIGH_POWER = 4'h1;
  localparam logic [3:0]  REG_CUT_LO     = 4'h2;
  localparam logic [3:0]  REG_CUT_HI     = 4'h3;
  localparam logic [3:0]  REG_TIMING     = 4'h4;
  localparam logic [3:0]  REG_FAULT      = 4'h5;
  localparam logic [3:0]  REG_MASK       = 4'h6;
  localparam logic [3:0]  REG_PORT_ON    = 4'h7;
  localparam logic [3:0]  REG_CLASS      = 4'h8;
  // Field positions
  localparam int          CTL_SELF_BIT   = 0;
  localparam int          CTL_SMALL_BIT  = 1;
  localparam int          FLT_START_LSB  = 0;
  localparam int          FLT_OVLD_LSB   = 4;
  localparam logic [7:0]  RESET_ZERO     = 8'h00;
  localparam logic [11:0] CUT_RESET      = 12'h000;
  localparam logic [1:0]  CLASS_HIGH     = 2'h3;
  localparam logic [2:0]  CUT_SELF_LOW   = 3'h0;
  localparam logic [2:0]  CUT_SELF_HIGH  = 3'h6;

  typedef enum logic [1:0] {ST_OFF, ST_START, ST_ON} port_state_type;

  typedef struct packed {
    logic         at_inrush;
    logic         over_cut;
    logic         at_hard;
    logic         power_good;
    logic         short_det;
  } sense_type;

  typedef struct packed {
    logic         write;
    logic         read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bus_req_type;

  // Mapping of the cut code to the nominal mA value
  function automatic logic [9:0] cut_ma(input logic [2:0] code);
    unique case (code)
      3'h0:    cut_ma = 10'd374;
      3'h1:    cut_ma = 10'd110;
      3'h2:    cut_ma = 10'd204;
      3'h3:    cut_ma = 10'd374;
      3'h4:    cut_ma = 10'd754;
      3'h5:    cut_ma = 10'd592;
      3'h6:    cut_ma = 10'd645;
      3'h7:    cut_ma = 10'd920;
    endcase
  endfunction
endpackage

// ==== core/oc_guard.sv ====
// Four-port overcurrent protection sequencer: start-up, overload-cut and hard-limit timers.
// Assumes analog comparators feed the sense inputs; they are asynchronous and synchronised here.
`timescale 1ns/10ps
module oc_guard
  import oc_guard_pkg::*;
#(
  parameter int N              = NUM_PORTS,
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int OVLD_UNIT      = OVLD_UNIT_CYC
)(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  // Register port
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic      [DATA_W-1:0] rdata_out,
  // Per-port analog sense, asynchronous
  input  wire sense_type [N-1:0] sense_in,
  // Per-port drive
  output logic      [N-1:0]      port_on_out,
  output logic      [N-1:0]      inrush_limit_out,
  output logic      [N-1:0]      foldback_en_out,
  output logic      [N-1:0]      foldback_double_out,
  output logic      [N-1:0]      gate_zero_out,
  output logic      [N-1:0][2:0] cut_code_out,
  output logic                   small_sense_out,
  // Interrupt, active low level
  output logic                   irq_n_out
);
  // Register state
  logic [7:0]            ctl_q, ctl_d;
  logic [N-1:0]          hp_q, hp_d;
  logic [N-1:0][2:0]     cut_q, cut_d;
  logic [7:0]            tim_q, tim_d;
  logic [7:0]            mask_q, mask_d;
  logic [7:0]            clsd_q, clsd_d;
  logic [N-1:0]          start_f_q, start_f_d;
  logic [N-1:0]          ovld_f_q, ovld_f_d;
  logic [N-1:0]          lim_f_q, lim_f_d;
  logic [N-1:0]          req_on_q, req_on_d;
  logic [DATA_W-1:0]     rdata_q, rdata_d;
  logic                  irq_n_q, irq_n_d;
  // Sync stages
  sense_type [N-1:0]     s1_q, s2_q;
  // Port engines
  port_state_type [N-1:0] st_q, st_d;
  logic [N-1:0][TIMER_W-1:0] ovt_q, ovt_d, lmt_q, lmt_d, sut_q, sut_d;
  logic [N-1:0][15:0]    pre_q, pre_d;
  logic [N-1:0][3:0]     rdiv_q, rdiv_d;
  logic [N-1:0]          sup_start, sup_ovld, sup_lim;

  // Timeout in units from a 2-bit timing field
  function automatic logic [TIMER_W-1:0] tmax(input logic [1:0] f);
    tmax = TIMER_W'({f, 6'h3f}) + TIMER_W'(1);
  endfunction

  always_ff @(posedge mclk_in)
  begin
    s1_q <= sense_in;
    s2_q <= s1_q;
  end

  genvar p;
  generate
    for (p = 0; p < N; p++)
    begin : g_port
      always_comb
      begin
        st_d[p]      = st_q[p];
        sut_d[p]     = sut_q[p];
        ovt_d[p]     = ovt_q[p];
        lmt_d[p]     = lmt_q[p];
        pre_d[p]     = pre_q[p];
        rdiv_d[p]    = rdiv_q[p];
        sup_start[p] = 1'b0;
        sup_ovld[p]  = 1'b0;
        sup_lim[p]   = 1'b0;
        unique case (st_q[p])
          ST_OFF:
          begin
            if (req_on_q[p])
            begin
              st_d[p]  = ST_START;
              sut_d[p] = TIMER_W'(STARTUP_CYCLES);
              ovt_d[p] = tmax(tim_q[1:0]);
              lmt_d[p] = tmax(tim_q[3:2]);
              pre_d[p] = 16'h0000;
            end
          end
          ST_START:
          begin
            if (!req_on_q[p])
              st_d[p] = ST_OFF;
            else if (sut_q[p] > TIMER_W'(1))
              sut_d[p] = sut_q[p] - TIMER_W'(1);
            else if (s2_q[p].at_inrush)
            begin
              st_d[p]      = ST_OFF;
              sup_start[p] = 1'b1;
            end
            else
              st_d[p] = ST_ON;
          end
          ST_ON:
          begin
            // Prescaler ticks one timer unit; both timers share it per port
            pre_d[p] = (pre_q[p] >= 16'(OVLD_UNIT - 1)) ? 16'h0000 : pre_q[p] + 16'h0001;
            if (!req_on_q[p])
              st_d[p] = ST_OFF;
            else if (pre_q[p] >= 16'(OVLD_UNIT - 1))
            begin
              rdiv_d[p] = (rdiv_q[p] >= RECOVER_DIV - 4'h1) ? 4'h0 : rdiv_q[p] + 4'h1;
              if (s2_q[p].over_cut)
                ovt_d[p] = ovt_q[p] - TIMER_W'(1);
              else if (rdiv_q[p] == 4'h0 && ovt_q[p] < tmax(tim_q[1:0]))
                ovt_d[p] = ovt_q[p] + TIMER_W'(1);
              if (s2_q[p].at_hard && s2_q[p].power_good)
                lmt_d[p] = lmt_q[p] - TIMER_W'(1);
              else if (rdiv_q[p] == 4'h0 && lmt_q[p] < tmax(tim_q[3:2]))
                lmt_d[p] = lmt_q[p] + TIMER_W'(1);
              if (s2_q[p].over_cut && ovt_q[p] == TIMER_W'(1))
              begin
                st_d[p]     = ST_OFF;
                sup_ovld[p] = 1'b1;
              end
              if (s2_q[p].at_hard && s2_q[p].power_good && lmt_q[p] == TIMER_W'(1))
              begin
                st_d[p]    = ST_OFF;
                sup_lim[p] = 1'b1;
              end
            end
          end
        endcase
      end

      always_ff @(posedge mclk_in)
      begin
        if (!rst_n_in)
        begin
          st_q[p]   <= ST_OFF;
          sut_q[p]  <= '0;
          ovt_q[p]  <= '0;
          lmt_q[p]  <= '0;
          pre_q[p]  <= '0;
          rdiv_q[p] <= '0;
        end
        else
        begin
          st_q[p]   <= st_d[p];
          sut_q[p]  <= sut_d[p];
          ovt_q[p]  <= ovt_d[p];
          lmt_q[p]  <= lmt_d[p];
          pre_q[p]  <= pre_d[p];
          rdiv_q[p] <= rdiv_d[p];
        end
      end

      // Outputs registered from next state (foldback double from hp_q) so they stand straight from flops
      always_ff @(posedge mclk_in)
      begin
        if (!rst_n_in)
        begin
          port_on_out[p]         <= 1'b0;
          inrush_limit_out[p]    <= 1'b0;
          foldback_en_out[p]     <= 1'b0;
          foldback_double_out[p] <= 1'b0;
          gate_zero_out[p]       <= 1'b0;
        end
        else
        begin
          port_on_out[p]         <= (st_d[p] != ST_OFF);
          inrush_limit_out[p]    <= (st_d[p] == ST_START);
          foldback_en_out[p]     <= (st_d[p] == ST_ON) && s2_q[p].power_good;
          foldback_double_out[p] <= hp_q[p];
          gate_zero_out[p]       <= (st_d[p] == ST_ON) && s2_q[p].short_det;
        end
      end
    end
  endgenerate

  // Register file and self-managed programming
  always_comb
  begin
    ctl_d    = ctl_q;
    hp_d     = hp_q;
    cut_d    = cut_q;
    tim_d    = tim_q;
    mask_d   = mask_q;
    clsd_d   = clsd_q;
    req_on_d = req_on_q;
    rdata_d  = RESET_ZERO;
    if (wr_in)
    begin
      unique case (addr_in)
        REG_CONTROL:    ctl_d = wdata_in;
        REG_HIGH_POWER: hp_d = wdata_in[N-1:0];
        REG_CUT_LO:     {cut_d[1], cut_d[0]} = {wdata_in[6:4], wdata_in[2:0]};
        REG_CUT_HI:     {cut_d[3], cut_d[2]} = {wdata_in[6:4], wdata_in[2:0]};
        REG_TIMING:     tim_d = wdata_in;
        REG_MASK:       mask_d = wdata_in;
        REG_PORT_ON:    req_on_d = wdata_in[N-1:0];
        REG_CLASS:      clsd_d = wdata_in;
        default:        ;
      endcase
    end
    for (int i = 0; i < N; i++)
    begin
      if (st_d[i] == ST_OFF && st_q[i] != ST_OFF)
        req_on_d[i] = 1'b0;
      // Self-managed: settings fixed from class while still off
      if (ctl_q[CTL_SELF_BIT] && st_q[i] == ST_OFF)
      begin
        hp_d[i]  = (clsd_q[2*i +: 2] == CLASS_HIGH);
        cut_d[i] = hp_d[i] ? CUT_SELF_HIGH : CUT_SELF_LOW;
      end
    end
    if (rd_in)
    begin
      unique case (addr_in)
        REG_CONTROL:    rdata_d = ctl_q;
        REG_HIGH_POWER: rdata_d = DATA_W'(hp_q);
        REG_CUT_LO:     rdata_d = {1'b0, cut_q[1], 1'b0, cut_q[0]};
        REG_CUT_HI:     rdata_d = {1'b0, cut_q[3], 1'b0, cut_q[2]};
        REG_TIMING:     rdata_d = tim_q;
        REG_FAULT:      rdata_d = {ovld_f_q, start_f_q};
        REG_MASK:       rdata_d = mask_q;
        REG_PORT_ON:    rdata_d = DATA_W'(req_on_q);
        REG_CLASS:      rdata_d = DATA_W'(lim_f_q);
        default:        rdata_d = RESET_ZERO;
      endcase
    end
    // Read clears, but a same-cycle event still wins
    start_f_d = (rd_in && addr_in == REG_FAULT) ? '0 : start_f_q;
    ovld_f_d  = (rd_in && addr_in == REG_FAULT) ? '0 : ovld_f_q;
    lim_f_d   = (rd_in && addr_in == REG_CLASS) ? '0 : lim_f_q;
    start_f_d = start_f_d | sup_start;
    ovld_f_d  = ovld_f_d | sup_ovld;
    lim_f_d   = lim_f_d | sup_lim;
    irq_n_d   = ~(|({ovld_f_d, start_f_d} & mask_q) | |(lim_f_d & ctl_q[7:4]));
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      ctl_q     <= RESET_ZERO;
      hp_q      <= '0;
      cut_q     <= CUT_RESET;
      tim_q     <= RESET_ZERO;
      mask_q    <= RESET_ZERO;
      clsd_q    <= RESET_ZERO;
      req_on_q  <= '0;
      start_f_q <= '0;
      ovld_f_q  <= '0;
      lim_f_q   <= '0;
      rdata_q   <= RESET_ZERO;
      irq_n_q   <= 1'b1;
    end
    else
    begin
      ctl_q     <= ctl_d;
      hp_q      <= hp_d;
      cut_q     <= cut_d;
      tim_q     <= tim_d;
      mask_q    <= mask_d;
      clsd_q    <= clsd_d;
      req_on_q  <= req_on_d;
      start_f_q <= start_f_d;
      ovld_f_q  <= ovld_f_d;
      lim_f_q   <= lim_f_d;
      rdata_q   <= rdata_d;
      irq_n_q   <= irq_n_d;
    end
  end

  assign rdata_out       = rdata_q;
  assign irq_n_out       = irq_n_q;
  assign cut_code_out    = cut_q;
  assign small_sense_out = ctl_q[CTL_SMALL_BIT];

  a_inrush_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_q[0] == ST_START && sut_q[0] > TIMER_W'(1) && req_on_q[0])
    |=> st_q[0] == ST_START && inrush_limit_out[0])
    else $error("inrush limit not held in start-up");
  a_start_fault: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sup_start[0] |=> start_f_q[0] && st_q[0] == ST_OFF)
    else $error("start-up fault not flagged");
  a_no_tier_start: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_q[1] == ST_START) |-> !sup_ovld[1] && !sup_lim[1])
    else $error("tier acted during start-up");
  a_ovld_fault: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sup_ovld[1] |=> ovld_f_q[1] && !port_on_out[1])
    else $error("overload expiry not handled");
  a_ovld_sat: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_q[3] == ST_ON) |-> ovt_q[3] <= tmax(tim_q[1:0]))
    else $error("overload timer above max");
  a_lim_sat: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_q[2] == ST_ON && $stable(tim_q)) |-> lmt_q[2] <= tmax(tim_q[3:2]))
    else $error("limit timer above max");
  a_lim_fault: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sup_lim[2] |=> lim_f_q[2] && !port_on_out[2])
    else $error("limit expiry not handled");
  a_flag_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (ovld_f_q[1] && !(rd_in && addr_in == REG_FAULT)) |=> ovld_f_q[1])
    else $error("fault flag dropped without clear");
  a_fold_pg: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    foldback_en_out[3] |-> port_on_out[3] && !inrush_limit_out[3])
    else $error("foldback while off");
  c_start_fail: cover property (@(posedge mclk_in) sup_start[0]);
  c_ovld_trip: cover property (@(posedge mclk_in) sup_ovld[1]);
  c_lim_trip: cover property (@(posedge mclk_in) sup_lim[2]);
  c_irq: cover property (@(posedge mclk_in) !irq_n_q);
endmodule // oc_guard

// ==== sim/pd_model.sv ====
// Powered-device model: turns a per-port load mode into comparator levels.
// Assumes the guard samples these levels through its own synchronisers.
`timescale 1ns/10ps
module pd_model
  import oc_guard_pkg::*;
#(
  parameter int N = NUM_PORTS
)(
  // Clock
  input  wire logic              mclk_in,
  // Guard drive and load mode: 0 normal, 1 stuck at inrush, 2 overload, 3 short
  input  wire logic [N-1:0]      port_on_in,
  input  wire logic [N-1:0]      inrush_in,
  input  wire logic [N-1:0][1:0] load_in,
  // Comparator levels
  output sense_type [N-1:0]      sense_out
);
  always_ff @(posedge mclk_in)
  begin
    for (int i = 0; i < N; i++)
    begin
      // An unpowered port draws nothing, so every comparator reads low
      sense_out[i].at_inrush  <= port_on_in[i] && inrush_in[i] && load_in[i] == 2'h1;
      sense_out[i].over_cut   <= port_on_in[i] && load_in[i][1];
      sense_out[i].at_hard    <= port_on_in[i] && load_in[i] == 2'h3;
      sense_out[i].power_good <= port_on_in[i] && !inrush_in[i];
      sense_out[i].short_det  <= port_on_in[i] && load_in[i] == 2'h3;
    end
  end
endmodule // pd_model

// ==== sim/tb.sv ====
// Self-checking bench for the overcurrent guard with a powered-device model.
// Assumes short sim timers: 20-cycle start-up, 2-cycle timer unit.
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb;
  import oc_guard_pkg::*;
  localparam int SU   = 20;
  localparam int UNIT = 2;
  localparam int OVC  = 128 * UNIT;
  localparam int LMC  = 64 * UNIT;
  logic                      mclk_in = 1'b0;
  logic                      rst_n_in = 1'b0;
  logic                      wr_in = 1'b0;
  logic                      rd_in = 1'b0;
  logic [ADDR_W-1:0]         addr_in = '0;
  logic [DATA_W-1:0]         wdata_in = '0;
  logic [DATA_W-1:0]         rdata_out;
  sense_type [NUM_PORTS-1:0] sense;
  logic [NUM_PORTS-1:0][1:0] load = '0;
  logic [NUM_PORTS-1:0]      port_on_out, inrush_limit_out, foldback_en_out;
  logic [NUM_PORTS-1:0]      foldback_double_out, gate_zero_out;
  logic [NUM_PORTS-1:0][2:0] cut_code_out;
  logic                      small_sense_out, irq_n_out;
  int                        n_errors = 0;
  int                        cmp_count = 0;
  logic [7:0]                exp_q[$];
  logic [7:0]                exp_v, c01, c23;
  logic                      rd_pend = 1'b0;
  logic [15:0]               lf = 16'ha689;
  logic [3:0]                hp;

  always #5 mclk_in = ~mclk_in;

  oc_guard #(.N(NUM_PORTS), .STARTUP_CYCLES(SU), .OVLD_UNIT(UNIT)) oc_guard_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .wr_in(wr_in), .rd_in(rd_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .sense_in(sense),
    .port_on_out(port_on_out), .inrush_limit_out(inrush_limit_out),
    .foldback_en_out(foldback_en_out), .foldback_double_out(foldback_double_out),
    .gate_zero_out(gate_zero_out), .cut_code_out(cut_code_out),
    .small_sense_out(small_sense_out), .irq_n_out(irq_n_out));

  pd_model #(.N(NUM_PORTS)) pd_model_inst (
    .mclk_in(mclk_in), .port_on_in(port_on_out), .inrush_in(inrush_limit_out),
    .load_in(load), .sense_out(sense));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Waits land one step past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
  endtask

  task automatic setld(input int p, input logic [1:0] v);
    @(posedge mclk_in);
    load[p] <= v;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_in)
  begin
    if (rd_pend)
    begin
      exp_v = exp_q.pop_front();
      `CHK(rdata_out, exp_v)
    end
    rd_pend = rd_in;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 9; a++)
      rd(a[3:0], RESET_ZERO);
    rd(4'hf, 8'h00);
    `CHK(irq_n_out, 1'b1)
    lf = lfsr(lf);
    c01 = lf[7:0] & 8'h77;
    lf = lfsr(lf);
    c23 = lf[7:0] & 8'h77;
    hp = {c23[6], c23[2], c01[6], c01[2]};
    wr(REG_CUT_LO, c01);
    wr(REG_CUT_HI, c23);
    wr(REG_HIGH_POWER, {4'h0, hp});
    wr(REG_TIMING, 8'h01);
    wr(REG_CONTROL, 8'h42);
    wr(REG_MASK, 8'h21);
    rd(REG_CUT_LO, c01);
    rd(REG_CUT_HI, c23);
    cyc(2);
    `CHK(cut_code_out[0], c01[2:0])
    `CHK(cut_code_out[3], c23[6:4])
    `CHK(foldback_double_out, hp)
    `CHK(small_sense_out, 1'b1)
    // Port 0 never leaves the inrush limit
    setld(0, 2'h1);
    wr(REG_PORT_ON, 8'h01);
    cyc(3);
    `CHK(inrush_limit_out[0], 1'b1)
    `CHK(foldback_en_out[0], 1'b0)
    cyc(SU + 8);
    `CHK(port_on_out[0], 1'b0)
    `CHK(irq_n_out, 1'b0)
    rd(REG_FAULT, 8'h01);
    rd(REG_FAULT, 8'h00);
    cyc(2);
    `CHK(irq_n_out, 1'b1)
    // Port 1 overloaded from switch-on, port 3 healthy beside it
    setld(1, 2'h2);
    wr(REG_PORT_ON, 8'h0a);
    cyc(3);
    `CHK(foldback_en_out[3], 1'b0)
    `CHK(inrush_limit_out[3], 1'b1)
    cyc(SU + OVC - 10);
    `CHK(port_on_out[1], 1'b1)
    `CHK(foldback_en_out[3], 1'b1)
    cyc(30);
    `CHK(port_on_out, 4'h8)
    `CHK(irq_n_out, 1'b0)
    rd(REG_FAULT, 8'h20);
    // Recovery must buy back time, but never beyond the configured timeout
    setld(3, 2'h2);
    cyc(200);
    setld(3, 2'h0);
    cyc(400);
    setld(3, 2'h2);
    cyc(90);
    `CHK(port_on_out[3], 1'b1)
    setld(3, 2'h0);
    cyc(3000);
    setld(3, 2'h2);
    cyc(OVC - 10);
    `CHK(port_on_out[3], 1'b1)
    cyc(24);
    `CHK(port_on_out[3], 1'b0)
    `CHK(irq_n_out, 1'b1)
    rd(REG_FAULT, 8'h80);
    // Short on port 2 after start-up
    wr(REG_PORT_ON, 8'h04);
    cyc(3);
    `CHK(inrush_limit_out[2], 1'b1)
    cyc(SU + 3);
    setld(2, 2'h3);
    cyc(4);
    `CHK(gate_zero_out[2], 1'b1)
    cyc(LMC - 14);
    `CHK(port_on_out[2], 1'b1)
    cyc(24);
    `CHK(port_on_out[2], 1'b0)
    `CHK(irq_n_out, 1'b0)
    rd(REG_CLASS, 8'h04);
    rd(REG_CLASS, 8'h00);
    // Self-managed: class decides cut code and curve
    setld(0, 2'h0);
    setld(3, 2'h0);
    wr(REG_CONTROL, 8'h01);
    wr(REG_CLASS, 8'h03);
    wr(REG_PORT_ON, 8'h09);
    cyc(4);
    `CHK(cut_code_out[0], CUT_SELF_HIGH)
    `CHK(foldback_double_out[0], 1'b1)
    `CHK(cut_code_out[3], CUT_SELF_LOW)
    `CHK(foldback_double_out[3], 1'b0)
    `CHK(small_sense_out, 1'b0)
    cyc(4);
    tally_and_finish();
  end
endmodule // tb
